/* File: overlay_dma_mem_model.sv */
// Behavioural descriptor memory at the far side of the fetch port
module overlay_dma_mem_model
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Descriptor read port
    input wire overlay_dma_pkg::mem_req_t mem_req,
    output logic mem_ready,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    import overlay_dma_pkg::*;
    logic [31:0] addr_r;
    logic [1:0] dly_r;
    logic [1:0] word_r;
    logic busy_r;
    ////////////////////////////////////////////////////////////////
    // Ready toggles so takes are both prompt and stalled; idle data
    // is inverted every cycle so a stale word never looks valid.
    // Word 0 start, word 1 control with continue clear, word 2 next
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_ready <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            busy_r <= 1'b0;
            dly_r <= 2'h0;
            word_r <= 2'h0;
            addr_r <= 32'h0000_0000;
        end
        else
        begin
            mem_ready <= ~mem_ready;
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.req && mem_ready && !busy_r)
            begin
                busy_r <= 1'b1;
                addr_r <= mem_req.addr;
                dly_r <= 2'h2;
            end
            else if (busy_r && dly_r != 2'h0)
                dly_r <= dly_r - 2'h1;
            else if (busy_r)
            begin
                busy_r <= 1'b0;
                mem_rvalid <= 1'b1;
                word_r <= (word_r == 2'h2) ? 2'h0 : word_r + 2'h1;
                mem_rdata <= (word_r == 2'h0) ? addr_r ^ 32'h00a0_0000 :
                             (word_r == 2'h1) ? 32'h0000_0000 : addr_r + 32'h0000_0100;
            end
        end
    end
endmodule : overlay_dma_mem_model

/* File: overlay_dma_pkg.sv */
// Constants, types and register map of the overlay layer DMA channel block
package overlay_dma_pkg;

    // Channel count and channel indices
    localparam int NUM_CH = 3;
    localparam logic [1:0] CH_MAIN = 2'h0;
    localparam logic [1:0] CH_U = 2'h1;
    localparam logic [1:0] CH_V = 2'h2;

    // Register byte addresses
    localparam logic [31:0] IRQ_CLEAR_ADDR = 32'hf803_8290;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hf803_8294;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hf803_8298;
    localparam logic [31:0] MAIN_HEAD_ADDR = 32'hf803_829c;
    localparam logic [31:0] MAIN_START_ADDR = 32'hf803_82a0;
    localparam logic [31:0] MAIN_CTRL_ADDR = 32'hf803_82a4;
    localparam logic [31:0] MAIN_NEXT_ADDR = 32'hf803_82a8;
    localparam logic [31:0] U_HEAD_ADDR = 32'hf803_82ac;
    localparam logic [31:0] U_START_ADDR = 32'hf803_82b0;
    localparam logic [31:0] U_CTRL_ADDR = 32'hf803_82b4;
    localparam logic [31:0] U_NEXT_ADDR = 32'hf803_82b8;
    localparam logic [31:0] V_HEAD_ADDR = 32'hf803_82bc;
    localparam logic [31:0] V_START_ADDR = 32'hf803_82c0;
    localparam logic [31:0] V_CTRL_ADDR = 32'hf803_82c4;

    // Channel control field positions
    localparam int CTRL_W = 6;
    localparam int CTRL_FETCH_BIT = 0;
    localparam int CTRL_LUT_BIT = 1;
    localparam int CTRL_XFER_DONE_N_BIT = 2;
    localparam int CTRL_DESC_LOADED_N_BIT = 3;
    localparam int CTRL_HEAD_ADDED_N_BIT = 4;
    localparam int CTRL_END_OF_LIST_BIT = 5;
    localparam logic [5:0] CTRL_MASK_MAIN = 6'h3f;
    localparam logic [5:0] CTRL_MASK_CHROMA = 6'h3d;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Interrupt status layout: five events per channel, eight bits apart
    localparam int NUM_EV = 5;
    localparam int EV_XFER_DONE = 0;
    localparam int EV_DESC_LOADED = 1;
    localparam int EV_HEAD_ADDED = 2;
    localparam int EV_END_OF_LIST = 3;
    localparam int EV_OVERFLOW = 4;
    localparam int STAT_LSB = 2;
    localparam int STAT_STRIDE = 8;
    localparam logic [31:0] STAT_MASK = 32'h007c_7c7c;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // Descriptor in memory: start address, control word, next pointer
    localparam logic [1:0] DESC_START_WORD = 2'h0;
    localparam logic [1:0] DESC_CTRL_WORD = 2'h1;
    localparam logic [1:0] DESC_NEXT_WORD = 2'h2;
    localparam int DESC_CONT_BIT = 0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b10,
        ST_XFER = 2'b11
    } fetch_state_t;

    typedef enum logic [3:0] {
        RID_NONE = 4'b0000,
        RID_CLEAR = 4'b0001,
        RID_MASK = 4'b0010,
        RID_STATUS = 4'b0011,
        RID_HEAD = 4'b0100,
        RID_START = 4'b0101,
        RID_CTRL = 4'b0110,
        RID_NEXT = 4'b0111
    } reg_kind_t;

    // Decoded register: kind and channel
    typedef struct packed {
        reg_kind_t kind;
        logic [1:0] ch;
    } reg_id_t;

    // Descriptor memory read request
    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } mem_req_t;

endpackage : overlay_dma_pkg

/* File: overlay_layer_dma_channel_regs.sv */
// Register file and descriptor fetch sequencer of the three overlay DMA channels
//
// Contract
// - Main channel fetches descriptors only while its fetch enable bit is 1; the sequencer finishes a fetch under way after the bit clears.
// - Lookup table DMA load is allowed only while the lookup fetch bit is 1.
// - Main transfer-done interrupt enable is active low.
// - Main descriptor-loaded interrupt enable is active low.
// - Main head-added interrupt enable is active low.
// - Main end-of-list interrupt enable is active high.
// - U/UV channel fetches descriptors only while its fetch enable bit is 1; the sequencer finishes a fetch under way after the bit clears.
// - U/UV transfer-done, descriptor-loaded and head-added enables are active low.
// - U/UV end-of-list interrupt enable is active high.
// - V channel fetches descriptors only while its fetch enable bit is 1; the sequencer finishes a fetch under way after the bit clears.
// - V transfer-done interrupt enable is active low.
// - Each head pointer register holds the next new descriptor address.
// - Main start address register holds the frame buffer base address.
// - U/UV start address register holds the chroma U or UV buffer address.
// - V start address register holds the chroma V buffer address.
// - Reading the status register clears the interrupt flags.
// - A source reaches the interrupt output only when its mask bit is 1.
module overlay_layer_dma_channel_regs
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM register slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Descriptor memory read master
    output overlay_dma_pkg::mem_req_t mem_req,
    input wire logic mem_ready,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    // Pixel transfer side, one lane per channel
    output logic [2:0] xfer_start,
    output logic [2:0][31:0] xfer_addr,
    input wire logic [2:0] xfer_done,
    input wire logic [2:0] overflow,
    // Lookup table load handshake
    input wire logic lut_load_req,
    output logic lut_load_grant,
    // Interrupt
    output logic irq
);
    import overlay_dma_pkg::*;

    typedef struct packed {
        logic [NUM_CH-1:0][31:0] head;
        logic [NUM_CH-1:0][31:0] start;
        logic [NUM_CH-1:0][31:0] next;
        logic [NUM_CH-1:0][CTRL_W-1:0] ctrl;
        logic [NUM_CH-1:0] head_pend;
        logic [NUM_CH-1:0] next_pend;
        logic [31:0] status;
        logic [31:0] irq_mask;
        fetch_state_t fsm;
        logic [1:0] cur;
        logic [1:0] word_idx;
        logic from_head;
        logic desc_cont;
        logic [31:0] fetch_ptr;
        logic rd_ack;
        logic [31:0] rdata;
        logic [NUM_CH-1:0] xfer_start;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    reg_id_t rid;
    logic [NUM_CH-1:0][NUM_EV-1:0] ev;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] gate_bits;
    logic [31:0] rd_val;
    logic found;
    logic [1:0] pick;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Address decode, shared by the read mux and the write path
    function automatic reg_id_t decode(input logic [31:0] a);
        reg_id_t r;
        r.kind = RID_NONE;
        r.ch = CH_MAIN;
        case (a)
            IRQ_CLEAR_ADDR: r.kind = RID_CLEAR;
            IRQ_MASK_ADDR: r.kind = RID_MASK;
            IRQ_STATUS_ADDR: r.kind = RID_STATUS;
            MAIN_HEAD_ADDR: r.kind = RID_HEAD;
            MAIN_START_ADDR: r.kind = RID_START;
            MAIN_CTRL_ADDR: r.kind = RID_CTRL;
            MAIN_NEXT_ADDR: r.kind = RID_NEXT;
            U_HEAD_ADDR: r = '{RID_HEAD, CH_U};
            U_START_ADDR: r = '{RID_START, CH_U};
            U_CTRL_ADDR: r = '{RID_CTRL, CH_U};
            U_NEXT_ADDR: r = '{RID_NEXT, CH_U};
            V_HEAD_ADDR: r = '{RID_HEAD, CH_V};
            V_START_ADDR: r = '{RID_START, CH_V};
            V_CTRL_ADDR: r = '{RID_CTRL, CH_V};
            default: r.kind = RID_NONE;
        endcase
        return r;
    endfunction : decode

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Per-event interrupt gate taken from a control register
    function automatic logic [NUM_EV-1:0] ctrl_gate(input logic [CTRL_W-1:0] c);
        logic [NUM_EV-1:0] g;
        g = '0;
        g[EV_XFER_DONE] = ~c[CTRL_XFER_DONE_N_BIT];
        g[EV_DESC_LOADED] = ~c[CTRL_DESC_LOADED_N_BIT];
        g[EV_HEAD_ADDED] = ~c[CTRL_HEAD_ADDED_N_BIT];
        g[EV_END_OF_LIST] = c[CTRL_END_OF_LIST_BIT];
        g[EV_OVERFLOW] = 1'b1;
        return g;
    endfunction : ctrl_gate

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Reads take one wait state so read data come from a flip-flop
    // Writes never wait, so a master never holds a write past its first edge
    assign rid = decode(address);
    assign waitrequest = read & ~s_r.rd_ack;
    assign readdata = s_r.rdata;
    assign xfer_start = s_r.xfer_start;
    assign xfer_addr = s_r.start;
    assign mem_req.req = (s_r.fsm == ST_REQ);
    assign mem_req.addr = s_r.fetch_ptr + {28'h000_0000, s_r.word_idx, 2'b00};
    assign lut_load_grant = lut_load_req & s_r.ctrl[CH_MAIN][CTRL_LUT_BIT];

    // Interrupt is a level: any flagged source passing both its mask and its control gate
    // Overflow has no control gate, so its mask bit alone holds it back
    always_comb
    begin
        gate_bits = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            gate_bits[STAT_LSB + c*STAT_STRIDE +: NUM_EV] = ctrl_gate(s_r.ctrl[c]);
        end
        irq = |(s_r.status & s_r.irq_mask & gate_bits);
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    // Unmapped, clear-register and reserved addresses all read as zero
    always_comb
    begin
        rd_val = WORD_RESET;
        case (rid.kind)
            RID_MASK: rd_val = s_r.irq_mask;
            RID_STATUS: rd_val = s_r.status;
            RID_HEAD: rd_val = s_r.head[rid.ch];
            RID_START: rd_val = s_r.start[rid.ch];
            RID_CTRL: rd_val = {26'h000_0000, s_r.ctrl[rid.ch]};
            RID_NEXT: rd_val = s_r.next[rid.ch];
            default: rd_val = WORD_RESET;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.xfer_start = '0;
        ev = '0;
        found = 1'b0;
        pick = CH_MAIN;
        clr_bits = '0;
        set_bits = '0;

        // Bus read: capture in the first cycle, complete in the second
        s_nxt.rd_ack = read & ~s_r.rd_ack;
        if (read & ~s_r.rd_ack)
        begin
            s_nxt.rdata = rd_val;
        end

        // Lowest-numbered enabled channel with queued work wins
        // A cleared fetch bit leaves that channel's queued work pending for later
        for (int c = NUM_CH - 1; c >= 0; c--)
        begin
            if (s_r.ctrl[c][CTRL_FETCH_BIT] & (s_r.head_pend[c] | s_r.next_pend[c]))
            begin
                found = 1'b1;
                pick = c[1:0];
            end
        end

        // Descriptor fetch sequencer; a disable only blocks the next start
        case (s_r.fsm)
            ST_IDLE:
            begin
                if (found)
                begin
                    s_nxt.cur = pick;
                    s_nxt.word_idx = DESC_START_WORD;
                    // A freshly written head beats the linked next pointer
                    s_nxt.from_head = s_r.head_pend[pick];
                    if (s_r.head_pend[pick])
                    begin
                        s_nxt.fetch_ptr = s_r.head[pick];
                        s_nxt.head_pend[pick] = 1'b0;
                    end
                    else
                    begin
                        s_nxt.fetch_ptr = s_r.next[pick];
                        s_nxt.next_pend[pick] = 1'b0;
                    end
                    s_nxt.fsm = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (mem_ready)
                begin
                    s_nxt.fsm = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (mem_rvalid)
                begin
                    case (s_r.word_idx)
                        DESC_START_WORD: s_nxt.start[s_r.cur] = mem_rdata;
                        DESC_CTRL_WORD: s_nxt.desc_cont = mem_rdata[DESC_CONT_BIT];
                        default: s_nxt.next[s_r.cur] = mem_rdata;
                    endcase
                    if (s_r.word_idx == DESC_NEXT_WORD)
                    begin
                        ev[s_r.cur][EV_DESC_LOADED] = 1'b1;
                        ev[s_r.cur][EV_HEAD_ADDED] = s_r.from_head;
                        s_nxt.xfer_start[s_r.cur] = 1'b1;
                        s_nxt.fsm = ST_XFER;
                    end
                    else
                    begin
                        s_nxt.word_idx = s_r.word_idx + 2'h1;
                        s_nxt.fsm = ST_REQ;
                    end
                end
            end
            ST_XFER:
            begin
                if (xfer_done[s_r.cur])
                begin
                    ev[s_r.cur][EV_XFER_DONE] = 1'b1;
                    // The list ends here unless the descriptor asked to go on
                    ev[s_r.cur][EV_END_OF_LIST] = ~s_r.desc_cont;
                    s_nxt.next_pend[s_r.cur] = s_r.desc_cont;
                    s_nxt.fsm = ST_IDLE;
                end
            end
            default: s_nxt.fsm = ST_IDLE;
        endcase

        // Bus writes come last so a head written now stays queued
        if (write)
        begin
            case (rid.kind)
                RID_CLEAR: clr_bits = writedata & {{8{byteenable[3]}}, {8{byteenable[2]}},
                                                   {8{byteenable[1]}}, {8{byteenable[0]}}};
                RID_MASK: s_nxt.irq_mask = merge(s_r.irq_mask, writedata, byteenable) & STAT_MASK;
                RID_HEAD:
                begin
                    s_nxt.head[rid.ch] = merge(s_r.head[rid.ch], writedata, byteenable);
                    s_nxt.head_pend[rid.ch] = 1'b1;
                end
                RID_START: s_nxt.start[rid.ch] = merge(s_r.start[rid.ch], writedata, byteenable);
                RID_CTRL:
                begin
                    if (byteenable[0])
                    begin
                        // Only documented bits are stored
                        s_nxt.ctrl[rid.ch] = writedata[CTRL_W-1:0] & ((rid.ch == CH_MAIN) ? CTRL_MASK_MAIN : CTRL_MASK_CHROMA);
                    end
                end
                RID_NEXT: s_nxt.next[rid.ch] = merge(s_r.next[rid.ch], writedata, byteenable);
                default: clr_bits = '0;
            endcase
        end

        // A status read completing this cycle clears only the flags it returned;
        // one set at the capture edge was never seen and must survive the read
        if (read & s_r.rd_ack & (rid.kind == RID_STATUS))
        begin
            clr_bits = s_r.rdata & STAT_MASK;
        end

        // Events, overflow included; a new event wins over a clear in the same cycle
        // Overflow is taken at any time, even while its channel is idle
        for (int c = 0; c < NUM_CH; c++)
        begin
            set_bits[STAT_LSB + c*STAT_STRIDE +: NUM_EV] = ev[c] | {overflow[c], 4'h0};
        end
        s_nxt.status = ((s_r.status & ~clr_bits) | set_bits) & STAT_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Active-low enables come out of reset on; the cleared mask keeps the line quiet
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.fsm <= ST_IDLE;
            s_r.ctrl <= {NUM_CH{CTRL_RESET}};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule : overlay_layer_dma_channel_regs

/* File: overlay_layer_dma_channel_regs_checker.sv */
// Port-level assertions of the overlay DMA channel register block
module overlay_layer_dma_channel_regs_checker
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Descriptor master
    input wire overlay_dma_pkg::mem_req_t mem_req,
    input wire logic mem_ready,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    // Pixel side, lookup table and interrupt
    input wire logic [2:0] xfer_start,
    input wire logic [2:0][31:0] xfer_addr,
    input wire logic [2:0] xfer_done,
    input wire logic [2:0] overflow,
    input wire logic lut_load_req,
    input wire logic lut_load_grant,
    input wire logic irq
);
    import overlay_dma_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] fetch_r;
    logic lut_r;
    logic [31:0] mask_r;
    logic [1:0] acc_r;
    logic [1:0] rv_r;
    ////////////////////////////////////////////////////////////////
    // Shadows of fetch bits and mask; word counters place each request
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fetch_r <= 3'h0;
            lut_r <= 1'b0;
            mask_r <= 32'h0000_0000;
            acc_r <= 2'h0;
            rv_r <= 2'h0;
        end
        else
        begin
            if (write && byteenable[0] && address == MAIN_CTRL_ADDR)
            begin
                fetch_r[0] <= writedata[0];
                lut_r <= writedata[1];
            end
            if (write && byteenable[0] && address == U_CTRL_ADDR)
                fetch_r[1] <= writedata[0];
            if (write && byteenable[0] && address == V_CTRL_ADDR)
                fetch_r[2] <= writedata[0];
            if (write && byteenable == 4'hf && address == IRQ_MASK_ADDR)
                mask_r <= writedata & STAT_MASK;
            if (mem_req.req && mem_ready)
                acc_r <= (acc_r == 2'h2) ? 2'h0 : acc_r + 2'h1;
            if (mem_rvalid)
                rv_r <= (rv_r == 2'h2) ? 2'h0 : rv_r + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence read_done;
        read && !waitrequest;
    endsequence
    sequence last_word;
        mem_rvalid && rv_r == 2'h2;
    endsequence
    a_write_no_wait: assert property (write |-> !waitrequest) else $error("write stalled");
    a_read_one_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest) else $error("read wait");
    a_fetch_gate: assert property ($rose(mem_req.req) && acc_r == 2'h0 |-> |fetch_r)
        else $error("fetch while disabled");
    a_lut_gate: assert property (lut_load_grant == (lut_load_req && lut_r))
        else $error("lookup grant wrong");
    a_irq_masked: assert property (irq |-> |mask_r) else $error("irq with mask clear");
    a_status_clear: assert property (read_done ##0 (address == IRQ_STATUS_ADDR && !mem_rvalid
        && !$past(mem_rvalid) && xfer_done == 3'h0 && overflow == 3'h0 && $past(xfer_done) == 3'h0
        && $past(overflow) == 3'h0) |=> !irq) else $error("status kept");
    a_req_hold: assert property (mem_req.req && !mem_ready |=> mem_req.req && $stable(mem_req.addr))
        else $error("request dropped");
    a_start_after_desc: assert property (last_word |-> ##[1:2] $onehot(xfer_start))
        else $error("no start pulse");
    a_ctrl_reserved: assert property (read_done ##0 (address == MAIN_CTRL_ADDR) |-> readdata[31:6] == 0)
        else $error("reserved bits set");
    a_unmapped_zero: assert property (read_done ##0 (address < IRQ_CLEAR_ADDR || address > V_CTRL_ADDR)
        |-> readdata == 32'h0000_0000) else $error("unmapped read");
endmodule : overlay_layer_dma_channel_regs_checker
bind overlay_layer_dma_channel_regs overlay_layer_dma_channel_regs_checker chk_u (.ref_clk, .rst_n, .address,
    .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .mem_req, .mem_ready, .mem_rvalid,
    .mem_rdata, .xfer_start, .xfer_addr, .xfer_done, .overflow, .lut_load_req, .lut_load_grant, .irq);

/* File: overlay_layer_dma_channel_regs_tb_top.sv */
// Self-checking bench of the overlay DMA channel register block
module overlay_layer_dma_channel_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import overlay_dma_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] address = 32'h0000_0000;
    logic [31:0] writedata = 32'h0000_0000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    mem_req_t mem_req;
    logic mem_ready;
    logic mem_rvalid;
    logic [31:0] mem_rdata;
    logic [2:0] xfer_start;
    logic [2:0][31:0] xfer_addr;
    logic [2:0] xfer_done = 3'h0;
    logic [2:0] overflow = 3'h0;
    logic lut_load_req = 1'b0;
    logic lut_load_grant;
    logic irq;
    logic [31:0] seed = 32'hc543_bf12;
    logic [31:0] exp_q[$];
    logic [31:0] rw_a[8] = '{MAIN_HEAD_ADDR, MAIN_START_ADDR, MAIN_NEXT_ADDR, U_HEAD_ADDR, U_START_ADDR,
                             U_NEXT_ADDR, V_HEAD_ADDR, V_START_ADDR};
    int n_fail = 0;
    int num_checks = 0;
    int n_acc = 0;
    overlay_layer_dma_channel_regs dut_u (.ref_clk, .rst_n, .address, .read, .write, .byteenable, .writedata,
        .readdata, .waitrequest, .mem_req, .mem_ready, .mem_rvalid, .mem_rdata, .xfer_start, .xfer_addr,
        .xfer_done, .overflow, .lut_load_req, .lut_load_grant, .irq);
    overlay_dma_mem_model mem_u (.ref_clk, .rst_n, .mem_req, .mem_ready, .mem_rvalid, .mem_rdata);
    ////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    // One Avalon transfer held until waitrequest is seen low; a read notes d as expected
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int i;
        logic w;
        i = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        if (!wr)
            exp_q.push_back(d);
        do
        begin
            @(posedge ref_clk);
            w = waitrequest;
            i++;
        end
        while (w !== 1'b0 && i < 50);
        if (w !== 1'b0)
        begin
            n_fail++;
            end_of_test();
        end
        write <= 1'b0;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    // Interrupt looked at mid-cycle, where the line has settled
    task automatic chk_irq(input logic e);
        @(negedge ref_clk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge ref_clk);
    endtask : chk_irq
    ////////////////////////////////////////////////////////////////
    // Monitor: each completed read takes the oldest note off the queue
    always @(negedge ref_clk)
    begin
        if (read === 1'b1 && waitrequest === 1'b0)
            chk(readdata, exp_q.pop_front());
    end
    // Descriptor requests taken by memory
    always @(posedge ref_clk)
    begin
        if (mem_req.req === 1'b1 && mem_ready === 1'b1)
            n_acc++;
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] v[8];
        logic [31:0] a;
        int k;
        int c;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (a = IRQ_CLEAR_ADDR; a <= V_CTRL_ADDR; a += 4)
            bus(1'b0, a, 32'h0000_0000);
        // Heads stay queued while every fetch bit is clear
        for (k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            v[k] = seed & 32'hffff_fffc;
            bus(1'b1, rw_a[k], v[k]);
            bus(1'b0, rw_a[k], v[k]);
        end
        repeat (10) @(posedge ref_clk);
        chk(n_acc, 0);
        chk(xfer_addr[0], v[1]);
        chk(xfer_addr[1], v[4]);
        chk(xfer_addr[2], v[7]);
        lut_load_req <= 1'b1;
        for (k = 0; k < 3; k++)
        begin
            bus(1'b1, MAIN_CTRL_ADDR + 16 * k, 32'hffff_fffe);
            bus(1'b0, MAIN_CTRL_ADDR + 16 * k, k == 0 ? 32'h0000_003e : 32'h0000_003c);
        end
        chk({31'h0, lut_load_grant}, 32'h0000_0001);
        bus(1'b1, MAIN_CTRL_ADDR, 32'h0000_0000);
        chk({31'h0, lut_load_grant}, 32'h0000_0000);
        bus(1'b1, V_CTRL_ADDR + 4, seed);
        bus(1'b0, V_CTRL_ADDR + 4, 32'h0000_0000);
        // Overflow needs only its mask; a read or the clear word removes it
        overflow <= 3'h1;
        @(posedge ref_clk);
        overflow <= 3'h4;
        @(posedge ref_clk);
        overflow <= 3'h0;
        chk_irq(1'b0);
        bus(1'b1, IRQ_MASK_ADDR, STAT_MASK);
        chk_irq(1'b1);
        bus(1'b1, IRQ_CLEAR_ADDR, 32'h0040_0000);
        bus(1'b0, IRQ_STATUS_ADDR, 32'h0000_0040);
        bus(1'b0, IRQ_STATUS_ADDR, 32'h0000_0000);
        chk_irq(1'b0);
        // Each channel once with its enables on and once with them off
        for (c = 0; c < 6; c++)
        begin
            k = c % 3;
            seed = lfsr(seed);
            a = seed & 32'h0fff_fff0;
            bus(1'b1, MAIN_HEAD_ADDR + 16 * k, a);
            bus(1'b1, MAIN_CTRL_ADDR + 16 * k, c < 3 ? 32'h0000_0021 : 32'h0000_001d);
            for (int i = 0; i < 300 && xfer_start === 3'h0; i++)
                @(negedge ref_clk);
            chk({29'h0, xfer_start}, 32'h1 << k);
            chk(xfer_addr[k], a ^ 32'h00a0_0000);
            if (xfer_start === 3'h0)
                end_of_test();
            @(posedge ref_clk);
            xfer_done[k] <= 1'b1;
            @(posedge ref_clk);
            xfer_done[k] <= 1'b0;
            repeat (2) @(posedge ref_clk);
            chk_irq(c < 3);
            bus(1'b0, IRQ_STATUS_ADDR, 32'h0000_003c << (8 * k));
            bus(1'b0, IRQ_STATUS_ADDR, 32'h0000_0000);
            // The memory returns next = word address + 0x100; V has no mapped next register
            bus(1'b0, MAIN_NEXT_ADDR + 16 * k, k < 2 ? a + 32'h0000_0108 : 32'h0000_0000);
            bus(1'b1, MAIN_CTRL_ADDR + 16 * k, 32'h0000_0000);
        end
        end_of_test();
    end
endmodule : overlay_layer_dma_channel_regs_tb_top
